/* design/spm_pkg.sv */
package spm_pkg;

  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned CNT_W     = 8;
  localparam int unsigned EDGE_W    = 4;
  localparam logic [3:0]  LAST_EDGE = 4'hF;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [7:0]  CNT_RST   = 8'h00;
  localparam logic [3:0]  EDGE_RST  = 4'h0;
  localparam logic        SS_IDLE   = 1'b1;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] half_div;
    logic       cpol;
    logic       cpha;
    logic [7:0] ss_delay;
    logic       rx_keep;
    logic       slave_sel;
  } spm_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } spm_tx_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELAY,
    ST_SHIFT,
    ST_HOLD,
    ST_END
  } spm_state_t;

endpackage

/* design/spm_buf.sv */
`timescale 1ns/1ps
`default_nettype none

module spm_buf (
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic       in_valid_i,
  input  wire logic [7:0] in_data_i,
  output logic            in_ready_o,
  output logic            out_valid_o,
  output logic [7:0]      out_data_o,
  input  wire logic       out_ready_i
);

  logic       v0;
  logic       v1;
  logic [7:0] d0;
  logic [7:0] d1;
  wire        push;
  wire        pop;

  // ------------------------------------------------------------
  // Handshakes
  // ------------------------------------------------------------
  assign in_ready_o  = ~v1;
  assign out_valid_o = v0;
  assign out_data_o  = d0;
  assign push        = in_valid_i & ~v1;
  assign pop         = v0 & out_ready_i;

  // ------------------------------------------------------------
  // Two entries, head always presented
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      v0 <= 1'b0;
      v1 <= 1'b0;
      d0 <= spm_pkg::BYTE_RST;
      d1 <= spm_pkg::BYTE_RST;
    end
    else if (ce_i)
    begin
      if (pop && push)
      begin
        if (v1)
        begin
          d0 <= d1;
          d1 <= in_data_i;
        end
        else
        begin
          d0 <= in_data_i;
        end
      end
      else if (pop)
      begin
        d0 <= d1;
        v0 <= v1;
        v1 <= 1'b0;
      end
      else if (push)
      begin
        if (!v0)
        begin
          d0 <= in_data_i;
          v0 <= 1'b1;
        end
        else
        begin
          d1 <= in_data_i;
          v1 <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* design/spm_master.sv */
`timescale 1ns/1ps
`default_nettype none

module spm_master (
  input  wire logic             ref_clk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire spm_pkg::spm_cfg_t cfg_i,
  input  wire logic             tx_valid_i,
  input  wire spm_pkg::spm_tx_t tx_i,
  output logic                  tx_ready_o,
  output logic                  rx_valid_o,
  output logic [7:0]            rx_data_o,
  input  wire logic             rx_ready_i,
  output logic                  tx_done_o,
  output logic                  rx_full_o,
  output logic                  busy_o,
  output logic                  sclk_o,
  output logic                  mosi_o,
  output logic                  ss0_n_o,
  output logic                  ss1_n_o,
  input  wire logic             miso_i
);

  spm_pkg::spm_state_t state;
  logic [7:0]          div_cnt;
  logic [7:0]          dly_cnt;
  logic [3:0]          edge_cnt;
  logic [7:0]          tx_sh;
  logic [7:0]          rx_sh;
  logic                last_q;
  logic                miso_m;
  logic                miso_s;
  logic                push;
  logic [7:0]          push_data;
  logic                buf_ready;

  // ------------------------------------------------------------
  // Edge classification
  // ------------------------------------------------------------
  function automatic logic is_sample(input logic [3:0] e, input logic cpha);
    is_sample = (e[0] == cpha);
  endfunction

  wire half_tick = (div_cnt == cfg_i.half_div);
  wire take      = tx_valid_i & tx_ready_o;
  wire sample_e  = half_tick & is_sample(edge_cnt, cfg_i.cpha);
  wire drive_e   = half_tick & ~is_sample(edge_cnt, cfg_i.cpha)
                   & (edge_cnt != spm_pkg::LAST_EDGE);
  wire byte_end  = half_tick & (edge_cnt == spm_pkg::LAST_EDGE);
  wire dly_done  = (dly_cnt >= cfg_i.ss_delay);

  // ------------------------------------------------------------
  // Incoming data synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
    end
    else if (ce_i)
    begin
      miso_m <= miso_i;
      miso_s <= miso_m;
    end
  end

  // ------------------------------------------------------------
  // Receive buffer
  // ------------------------------------------------------------
  spm_buf u_rx_buf (
    .ref_clk_i   (ref_clk_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .in_valid_i  (push),
    .in_data_i   (push_data),
    .in_ready_o  (buf_ready),
    .out_valid_o (rx_valid_o),
    .out_data_o  (rx_data_o),
    .out_ready_i (rx_ready_i)
  );

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      state      <= spm_pkg::ST_IDLE;
      div_cnt    <= spm_pkg::CNT_RST;
      dly_cnt    <= spm_pkg::CNT_RST;
      edge_cnt   <= spm_pkg::EDGE_RST;
      tx_sh      <= spm_pkg::BYTE_RST;
      rx_sh      <= spm_pkg::BYTE_RST;
      last_q     <= 1'b0;
      tx_ready_o <= 1'b0;
      tx_done_o  <= 1'b0;
      rx_full_o  <= 1'b0;
      busy_o     <= 1'b0;
      push       <= 1'b0;
      push_data  <= spm_pkg::BYTE_RST;
      sclk_o     <= 1'b0;
      mosi_o     <= 1'b0;
      ss0_n_o    <= spm_pkg::SS_IDLE;
      ss1_n_o    <= spm_pkg::SS_IDLE;
    end
    else if (ce_i)
    begin
      tx_ready_o <= 1'b0;
      tx_done_o  <= 1'b0;
      rx_full_o  <= 1'b0;
      push       <= 1'b0;
      unique case (state)
        spm_pkg::ST_IDLE:
        begin
          sclk_o <= cfg_i.cpol;
          busy_o <= 1'b0;
          if (take)
          begin
            ss0_n_o <= cfg_i.slave_sel;
            ss1_n_o <= ~cfg_i.slave_sel;
            tx_sh   <= tx_i.data;
            last_q  <= tx_i.last;
            dly_cnt <= spm_pkg::CNT_RST;
            busy_o  <= 1'b1;
            state   <= spm_pkg::ST_DELAY;
          end
          else
          begin
            tx_ready_o <= buf_ready;
          end
        end
        spm_pkg::ST_DELAY:
        begin
          dly_cnt <= dly_cnt + 8'h01;
          if (dly_done)
          begin
            div_cnt  <= spm_pkg::CNT_RST;
            edge_cnt <= spm_pkg::EDGE_RST;
            state    <= spm_pkg::ST_SHIFT;
            if (!cfg_i.cpha)
            begin
              mosi_o <= tx_sh[7];
              tx_sh  <= {tx_sh[6:0], 1'b0};
            end
          end
        end
        spm_pkg::ST_SHIFT:
        begin
          div_cnt <= half_tick ? spm_pkg::CNT_RST : div_cnt + 8'h01;
          if (half_tick)
          begin
            sclk_o   <= ~sclk_o;
            edge_cnt <= edge_cnt + 4'h1;
          end
          if (drive_e)
          begin
            mosi_o <= tx_sh[7];
            tx_sh  <= {tx_sh[6:0], 1'b0};
          end
          if (sample_e)
          begin
            rx_sh <= {rx_sh[6:0], miso_s};
          end
          if (byte_end)
          begin
            tx_done_o <= 1'b1;
            rx_full_o <= 1'b1;
            push      <= cfg_i.rx_keep;
            // Leading-edge sampling holds the whole byte already
            push_data <= cfg_i.cpha ? {rx_sh[6:0], miso_s} : rx_sh;
            state     <= last_q ? spm_pkg::ST_END : spm_pkg::ST_HOLD;
          end
        end
        spm_pkg::ST_HOLD:
        begin
          if (take)
          begin
            tx_sh    <= tx_i.data;
            last_q   <= tx_i.last;
            div_cnt  <= spm_pkg::CNT_RST;
            edge_cnt <= spm_pkg::EDGE_RST;
            state    <= spm_pkg::ST_SHIFT;
            if (!cfg_i.cpha)
            begin
              mosi_o <= tx_i.data[7];
              tx_sh  <= {tx_i.data[6:0], 1'b0};
            end
          end
          else
          begin
            tx_ready_o <= buf_ready & ~push;
          end
        end
        spm_pkg::ST_END:
        begin
          div_cnt <= div_cnt + 8'h01;
          if (half_tick)
          begin
            ss0_n_o <= spm_pkg::SS_IDLE;
            ss1_n_o <= spm_pkg::SS_IDLE;
            div_cnt <= spm_pkg::CNT_RST;
            state   <= spm_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state <= spm_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* tb/spm_master_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module spm_master_assertions (
  input wire logic              ref_clk_i,
  input wire logic              srst_i,
  input wire logic              ce_i,
  input wire spm_pkg::spm_cfg_t cfg_i,
  input wire logic              tx_valid_i,
  input wire logic              tx_ready_o,
  input wire logic              rx_valid_o,
  input wire logic              tx_done_o,
  input wire logic              rx_full_o,
  input wire logic              busy_o,
  input wire logic              sclk_o,
  input wire logic              ss0_n_o,
  input wire logic              ss1_n_o
);
  // --------------------
  // Port checks
  // --------------------
  wire logic sel_n = ss0_n_o & ss1_n_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence take_s;
    ce_i && tx_valid_i && tx_ready_o && !busy_o;
  endsequence
  sequence quiet_s;
    (!busy_o && $stable(cfg_i.cpol)) [*3];
  endsequence
  AST_TAKE_SEL: assert property (take_s |=> busy_o && !sel_n)
    else $error("select not opened by take");
  AST_IDLE_SEL: assert property (!busy_o |-> sel_n)
    else $error("select low while idle");
  AST_IDLE_CLK: assert property (quiet_s |-> sclk_o == cfg_i.cpol)
    else $error("clock off idle level");
  AST_SEL0: assert property (!ss0_n_o |-> !cfg_i.slave_sel)
    else $error("wrong select 0");
  AST_SEL1: assert property (!ss1_n_o |-> cfg_i.slave_sel)
    else $error("wrong select 1");
  AST_FLAGS: assert property ((tx_done_o || rx_full_o) |-> tx_done_o && rx_full_o ##1 !tx_done_o)
    else $error("byte flags apart");
  AST_RX_PUSH: assert property (rx_full_o && cfg_i.rx_keep |=> rx_valid_o)
    else $error("received byte lost");
  AST_WAIT_CLK: assert property (busy_o && tx_ready_o |-> sclk_o == cfg_i.cpol)
    else $error("clock moving while waiting");
  AST_HOLD_SEL: assert property (busy_o && !sel_n && tx_ready_o |=> !sel_n)
    else $error("select released between bytes");
endmodule
bind spm_master spm_master_assertions u_chk (.*);
`default_nettype wire

/* tb/spm_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spm_slave_model (
  input  wire logic  sclk_i,
  input  wire logic  ss_n_i,
  input  wire logic  mosi_i,
  input  wire logic  cpol_i,
  input  wire logic  cpha_i,
  output logic       miso_o,
  output logic [7:0] got_o,
  output int         edges_o
);
  // --------------------
  // Slave behaviour
  // --------------------
  logic [7:0] sh;
  int         n;
  int         k;
  initial
  begin
    miso_o = 1'b0;
    edges_o = 0;
  end
  always @(negedge ss_n_i)
  begin
    edges_o = 0;
    n = 0;
    sh = 8'hA5;
    k = cpha_i ? 0 : 1;
    if (!cpha_i)
      miso_o = sh[7];
  end
  // Released line shows inverse of last bit
  always @(posedge ss_n_i) miso_o = ~miso_o;
  always @(sclk_i)
  begin
    if (!ss_n_i)
    begin
      edges_o++;
      if ((sclk_i != cpol_i) ^ cpha_i)
      begin
        got_o = {got_o[6:0], mosi_i};
        n = (n + 1) % 8;
      end
      else
      begin
        sh = (n == 0) ? (8'hA5 ^ 8'(k)) : {sh[6:0], 1'b0};
        k = (n == 0) ? k + 1 : k;
        miso_o = sh[7];
      end
    end
  end
endmodule
`default_nettype wire

/* tb/spi_master_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_master_port_tb;
  // --------------------
  // Bench
  // --------------------
  logic ref_clk, srst, rdy, tx_valid, tx_ready, rx_valid, tx_done, rx_full;
  logic busy, sclk, mosi, ss0_n, ss1_n, miso, lsclk;
  logic [7:0] rx_data, got;
  spm_pkg::spm_cfg_t cfg;
  spm_pkg::spm_tx_t tx;
  int edges, errors, compares, cyc, t0, tf, tl, dl, ndone;
  logic [7:0] rxq[$];
  wire logic sel_n = ss0_n & ss1_n;
  spm_master dut (.ref_clk_i(ref_clk), .srst_i(srst), .ce_i(1'b1), .cfg_i(cfg),
    .tx_valid_i(tx_valid), .tx_i(tx), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_ready_i(rdy), .tx_done_o(tx_done), .rx_full_o(rx_full),
    .busy_o(busy), .sclk_o(sclk), .mosi_o(mosi), .ss0_n_o(ss0_n), .ss1_n_o(ss1_n),
    .miso_i(miso));
  spm_slave_model slv (.sclk_i(sclk), .ss_n_i(sel_n), .mosi_i(mosi), .cpol_i(cfg.cpol),
    .cpha_i(cfg.cpha), .miso_o(miso), .got_o(got), .edges_o(edges));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    ndone += int'(tx_done === 1'b1);
    if (rx_valid && rdy)
      rxq.push_back(rx_data);
    if (sel_n)
      t0 = cyc;
    else if (sclk !== lsclk)
    begin
      dl = (tf == 0) ? cyc - t0 : dl;
      tf = (tf == 0) ? cyc : tf;
      tl = cyc;
    end
    lsclk = sclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo(input int k);
    if (k >= 3000)
    begin
      chk("wait", 0, 1);
      wrap_up();
    end
  endtask
  task automatic frame(input logic [7:0] hd, input logic [2:0] m, input logic [7:0] dly,
      input logic keep, input int n);
    int k;
    cfg = '{hd, m[1], m[0], dly, keep, m[2]};
    repeat (3) @(negedge ref_clk);
    rxq.delete();
    ndone = 0;
    tf = 0;
    for (int i = 0; i < n; i++)
    begin
      tx_valid = 1'b1;
      tx = '{8'h3C + 8'(i * 17), i == n - 1};
      for (k = 0; k < 3000 && tx_ready !== 1'b1; k++)
        @(negedge ref_clk);
      tmo(k);
      @(negedge ref_clk);
    end
    tx_valid = 1'b0;
    for (k = 0; k < 3000 && busy !== 1'b0; k++)
      @(negedge ref_clk);
    tmo(k);
    chk("done", ndone, n);
    chk("edges", edges, 16 * n);
    chk("mosi", got, tx.data);
    chk("rxcount", rxq.size(), keep ? n : 0);
    for (int i = 0; i < rxq.size(); i++)
      chk("miso", rxq[i], 8'hA5 ^ 8'(i));
  endtask
  task automatic s_reset();
    chk("busy", busy, 1'b0);
    chk("sel", {ss0_n, ss1_n, tx_done, rx_valid}, 4'hC);
    chk("sclk", sclk, 1'b1);
  endtask
  task automatic s_modes();
    for (int m = 0; m < 8; m++)
      frame(8'h07, 3'(m), 8'h02, 1'b1, 3);
  endtask
  task automatic s_timing();
    int d1;
    int s1;
    frame(8'h07, 3'h0, 8'h02, 1'b1, 1);
    d1 = dl;
    s1 = tl - tf;
    frame(8'h07, 3'h0, 8'h14, 1'b0, 1);
    chk("delay", dl - d1, 18);
    frame(8'h03, 3'h3, 8'h02, 1'b1, 1);
    chk("span", {s1[15:0], 16'(tl - tf)}, {16'd120, 16'd60});
  endtask
  task automatic s_stall();
    rdy = 1'b0;
    fork
      begin
        repeat (700) @(negedge ref_clk);
        chk("held", {ndone[3:0], 3'h0, rx_valid}, 8'h21);
        rdy = 1'b1;
      end
    join_none
    frame(8'h07, 3'h5, 8'h02, 1'b1, 4);
  endtask
  initial
  begin
    srst = 1'b1;
    rdy = 1'b1;
    tx_valid = 1'b0;
    tx = '0;
    cfg = '{8'h07, 1'b1, 1'b0, 8'h02, 1'b1, 1'b0};
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
    repeat (6) @(negedge ref_clk);
    s_reset();
    s_modes();
    s_timing();
    s_stall();
    wrap_up();
  end
endmodule
`default_nettype wire
